// ===== rtl/srs_pkg.sv
// Purpose: constants, types and decode functions of the sensor register space
// Assumes: 64 byte-wide registers, one host access at a time
// Notes: reserved bits of a writable register always hold their default
//
// Contract
// - every function is reached only through host register reads and writes
// - each register is eight bits; one byte moves per access
// - one address space of 64 locations, 0x00 through 0x3F
// - written reserved bits are dropped and change no state
// - reserved bits read back unspecified; tests must not check them
// - addresses 0x00 to 0x0E are read-only; writes there are ignored
// - trigger bits (interrupt latch clear, reset command) are write-only, read zero
// - writing 0xB6 to 0x14 restores all defaults; host waits before reconfiguring
// - buffer policy 00 bypass, 01 fill-once, 10 overwrite-oldest; reads back
// - any buffer configuration write empties buffer and clears full/watermark

package srs_pkg;

   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_REGS = 64;
   localparam int unsigned NUM_STATUS = 15;

   localparam logic [5:0] ADDR_STATUS_LAST = 6'h0E;
   localparam logic [5:0] ADDR_SOFT_RESET = 6'h14;
   localparam logic [5:0] ADDR_INT_LATCH = 6'h21;
   localparam logic [5:0] ADDR_LOW_DUR = 6'h22;
   localparam logic [5:0] ADDR_MOTION_DUR = 6'h27;
   localparam logic [5:0] ADDR_SLOPE_THRESHOLD = 6'h28;
   localparam logic [5:0] ADDR_STILL_TH = 6'h29;
   localparam logic [5:0] ADDR_TAP_TIMING = 6'h2A;
   localparam logic [5:0] ADDR_TAP_THRESHOLD_CFG = 6'h2B;
   localparam logic [5:0] ADDR_ORIENT = 6'h2C;
   localparam logic [5:0] ADDR_ORIENT_ANGLE = 6'h2D;
   localparam logic [5:0] ADDR_LEVEL_ANGLE = 6'h2E;
   localparam logic [5:0] ADDR_WATERMARK = 6'h30;
   localparam logic [5:0] ADDR_SELF_CHECK = 6'h32;
   localparam logic [5:0] ADDR_NONVOLATILE = 6'h33;
   localparam logic [5:0] ADDR_HOST_IF = 6'h34;
   localparam logic [5:0] ADDR_CAL_CTRL = 6'h36;
   localparam logic [5:0] ADDR_CAL_TARGET = 6'h37;
   localparam logic [5:0] ADDR_TRIM_FIRST = 6'h38;
   localparam logic [5:0] ADDR_TRIM_SECOND = 6'h39;
   localparam logic [5:0] ADDR_TRIM_THIRD = 6'h3A;
   localparam logic [5:0] ADDR_BUFFER_CONFIG = 6'h3E;
   localparam logic [5:0] ADDR_BUFFER_READ = 6'h3F;

   localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;
   localparam int unsigned RESET_INT_BIT = 7;
   localparam int unsigned POLICY_LSB = 6;
   localparam int unsigned AXES_LSB = 0;

   localparam logic [7:0] RST_SLOPE_THRESHOLD = 8'h14;
   localparam logic [7:0] RST_STILL_TH = 8'h14;
   localparam logic [7:0] RST_TAP_TIMING = 8'h04;
   localparam logic [7:0] RST_TAP_THRESHOLD_CFG = 8'h0A;
   localparam logic [7:0] RST_ORIENT = 8'h18;
   localparam logic [7:0] RST_ORIENT_ANGLE = 8'h48;
   localparam logic [7:0] RST_LEVEL_ANGLE = 8'h08;
   localparam logic [7:0] RST_NONVOLATILE = 8'hF0;
   localparam logic [7:0] RST_CAL_CTRL = 8'h10;
   localparam logic [7:0] RST_ZERO = 8'h00;

   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] MASK_INT_LATCH = 8'h0F;
   localparam logic [7:0] MASK_TAP_TIMING = 8'hC7;
   localparam logic [7:0] MASK_TAP_THRESHOLD_CFG = 8'hDF;
   localparam logic [7:0] MASK_SEVEN = 8'h7F;
   localparam logic [7:0] MASK_SIX = 8'h3F;
   localparam logic [7:0] MASK_SELF_CHECK = 8'h17;
   localparam logic [7:0] MASK_NONVOLATILE = 8'h0F;
   localparam logic [7:0] MASK_HOST_IF = 8'h07;
   localparam logic [7:0] MASK_CAL_CTRL = 8'hE7;
   localparam logic [7:0] MASK_BUFFER_CONFIG = 8'hC3;

   typedef enum logic [1:0] {
      SRS_POLICY_BYPASS = 2'h0,
      SRS_POLICY_FILL_ONCE = 2'h1,
      SRS_POLICY_OVERWRITE = 2'h2,
      SRS_POLICY_UNUSED = 2'h3
   } srs_policy_type;

   typedef enum logic [1:0] {
      SRS_SRC_ZERO,
      SRS_SRC_STORE,
      SRS_SRC_CAPTURE
   } srs_src_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } srs_req_type;

   typedef logic [14:0][7:0] srs_status_type;

   function automatic logic [7:0] default_value(input logic [5:0] a);
      unique case (a)
         ADDR_SLOPE_THRESHOLD: default_value = RST_SLOPE_THRESHOLD;
         ADDR_STILL_TH: default_value = RST_STILL_TH;
         ADDR_TAP_TIMING: default_value = RST_TAP_TIMING;
         ADDR_TAP_THRESHOLD_CFG: default_value = RST_TAP_THRESHOLD_CFG;
         ADDR_ORIENT: default_value = RST_ORIENT;
         ADDR_ORIENT_ANGLE: default_value = RST_ORIENT_ANGLE;
         ADDR_LEVEL_ANGLE: default_value = RST_LEVEL_ANGLE;
         ADDR_NONVOLATILE: default_value = RST_NONVOLATILE;
         ADDR_CAL_CTRL: default_value = RST_CAL_CTRL;
         default: default_value = RST_ZERO;
      endcase
   endfunction : default_value

   function automatic logic [7:0] write_mask(input logic [5:0] a);
      unique case (a)
         ADDR_INT_LATCH: write_mask = MASK_INT_LATCH;
         ADDR_LOW_DUR, ADDR_MOTION_DUR, ADDR_SLOPE_THRESHOLD, ADDR_STILL_TH,
         ADDR_TRIM_FIRST, ADDR_TRIM_SECOND, ADDR_TRIM_THIRD: write_mask = MASK_FULL;
         ADDR_TAP_TIMING: write_mask = MASK_TAP_TIMING;
         ADDR_TAP_THRESHOLD_CFG: write_mask = MASK_TAP_THRESHOLD_CFG;
         ADDR_ORIENT, ADDR_ORIENT_ANGLE, ADDR_CAL_TARGET: write_mask = MASK_SEVEN;
         ADDR_LEVEL_ANGLE, ADDR_WATERMARK: write_mask = MASK_SIX;
         ADDR_SELF_CHECK: write_mask = MASK_SELF_CHECK;
         ADDR_NONVOLATILE: write_mask = MASK_NONVOLATILE;
         ADDR_HOST_IF: write_mask = MASK_HOST_IF;
         ADDR_CAL_CTRL: write_mask = MASK_CAL_CTRL;
         ADDR_BUFFER_CONFIG: write_mask = MASK_BUFFER_CONFIG;
         default: write_mask = MASK_NONE;
      endcase
   endfunction : write_mask

   // the trigger-only command register has no stored bits but is still mapped
   function automatic logic is_mapped(input logic [5:0] a);
      is_mapped = (a <= ADDR_STATUS_LAST) || (a == ADDR_SOFT_RESET) ||
         (a == ADDR_BUFFER_READ) || (write_mask(a) != MASK_NONE);
   endfunction : is_mapped

endpackage : srs_pkg

// ===== rtl/srs_reg_store.sv
// Purpose: byte store for the writable configuration registers
// Assumes: caller masks reserved bits before writing
// Notes: one write and one registered read per cycle
`timescale 1ns/1ps
`default_nettype none

module srs_reg_store (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [5:0] raddr,
   output logic [7:0] rdata_reg
);

   logic [7:0] mem_reg [0:srs_pkg::NUM_REGS-1];

   // flops rather than a ram macro: every byte must reload its default
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < srs_pkg::NUM_REGS; i++) begin
            mem_reg[i] <= srs_pkg::default_value(6'(i));
         end
      end else if (clr) begin
         for (int i = 0; i < srs_pkg::NUM_REGS; i++) begin
            mem_reg[i] <= srs_pkg::default_value(6'(i));
         end
      end else if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= mem_reg[raddr];
      end
   end

endmodule : srs_reg_store

`default_nettype wire

// ===== rtl/srs_register_space.sv
// Purpose: host register space of the acceleration sensor
// Assumes: host_req comes from the serial port front end on sys_clk
// Notes: read data appear two cycles after the request; write wins over read
`timescale 1ns/1ps
`default_nettype none

module srs_register_space (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire srs_pkg::srs_req_type host_req,
   input wire srs_pkg::srs_status_type core_status,
   input wire logic [7:0] buffer_data,
   output logic [7:0] rd_data_reg,
   output logic rd_valid_reg,
   output logic soft_reset_reg,
   output logic buffer_clear_reg,
   output logic buffer_pop_reg,
   output logic int_latch_clear_reg,
   output var srs_pkg::srs_policy_type buffer_policy_reg,
   output logic [1:0] buffer_axes_reg
);

   // access decode
   wire logic [5:0] acc_addr;
   wire logic [7:0] acc_wdata;
   wire logic wr_hit;
   wire logic rd_hit;
   wire logic read_only;
   wire logic [7:0] wmask;
   wire logic [7:0] store_wdata;
   wire logic store_we;
   wire logic soft_key;
   wire logic cfg_wr;
   wire logic wm_wr;
   wire logic latch_clr;
   wire logic pop_hit;
   wire logic mapped;
   wire logic [7:0] store_rdata;

   assign acc_addr = host_req.addr;
   assign acc_wdata = host_req.wdata;
   assign wr_hit = host_req.wr;
   // a write and a read in one cycle: the read is dropped
   assign rd_hit = host_req.rd && !host_req.wr;
   assign read_only = (acc_addr <= srs_pkg::ADDR_STATUS_LAST);
   assign wmask = srs_pkg::write_mask(acc_addr);
   // reserved bits keep their default, whatever the host sent
   assign store_wdata = (acc_wdata & wmask) |
      (srs_pkg::default_value(acc_addr) & ~wmask);
   assign store_we = wr_hit && !read_only && (wmask != srs_pkg::MASK_NONE);
   assign soft_key = wr_hit && (acc_addr == srs_pkg::ADDR_SOFT_RESET) &&
      (acc_wdata == srs_pkg::SOFT_RESET_KEY);
   assign cfg_wr = wr_hit && (acc_addr == srs_pkg::ADDR_BUFFER_CONFIG);
   assign wm_wr = wr_hit && (acc_addr == srs_pkg::ADDR_WATERMARK);
   assign latch_clr = wr_hit && (acc_addr == srs_pkg::ADDR_INT_LATCH) &&
      acc_wdata[srs_pkg::RESET_INT_BIT];
   assign pop_hit = rd_hit && (acc_addr == srs_pkg::ADDR_BUFFER_READ);
   assign mapped = srs_pkg::is_mapped(acc_addr);

   srs_reg_store u_store (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clr(soft_reset_reg),
      .we(store_we),
      .waddr(acc_addr),
      .wdata(store_wdata),
      .raddr(acc_addr),
      .rdata_reg(store_rdata)
   );

   // read pipeline, first stage: pick the source and capture live bytes
   srs_pkg::srs_src_type src_p1_reg;
   srs_pkg::srs_src_type src_p1_next;
   logic rd_p1_reg;
   logic [7:0] cap_p1_reg;
   logic [7:0] cap_p1_next;
   logic [7:0] rd_data_next;

   assign src_p1_next = (!mapped) ? srs_pkg::SRS_SRC_ZERO :
      (read_only || acc_addr == srs_pkg::ADDR_BUFFER_READ) ?
      srs_pkg::SRS_SRC_CAPTURE : srs_pkg::SRS_SRC_STORE;
   assign cap_p1_next = (acc_addr == srs_pkg::ADDR_BUFFER_READ) ? buffer_data :
      (read_only ? core_status[acc_addr[3:0]] : 8'h00);
   // trigger bits are never stored, so the store answers zero for them
   assign rd_data_next = (src_p1_reg == srs_pkg::SRS_SRC_STORE) ? store_rdata :
      (src_p1_reg == srs_pkg::SRS_SRC_CAPTURE) ? cap_p1_reg : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_p1_reg <= 1'b0;
         src_p1_reg <= srs_pkg::SRS_SRC_ZERO;
         cap_p1_reg <= 8'h00;
      end else begin
         rd_p1_reg <= rd_hit;
         src_p1_reg <= src_p1_next;
         cap_p1_reg <= cap_p1_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end else begin
         rd_valid_reg <= rd_p1_reg;
         rd_data_reg <= rd_p1_reg ? rd_data_next : 8'h00;
      end
   end

   // one-cycle command pulses toward the sensor core
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset_reg <= 1'b0;
         buffer_clear_reg <= 1'b0;
         buffer_pop_reg <= 1'b0;
         int_latch_clear_reg <= 1'b0;
      end else begin
         soft_reset_reg <= soft_key;
         // the watermark write also flushes, as the buffer controller expects
         buffer_clear_reg <= cfg_wr || wm_wr || soft_key;
         buffer_pop_reg <= pop_hit;
         int_latch_clear_reg <= latch_clr;
      end
   end

   // live copy of the buffer policy, so the buffer logic needs no store port
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         buffer_policy_reg <= srs_pkg::SRS_POLICY_BYPASS;
         buffer_axes_reg <= 2'h0;
      end else if (soft_reset_reg) begin
         buffer_policy_reg <= srs_pkg::SRS_POLICY_BYPASS;
         buffer_axes_reg <= 2'h0;
      end else if (cfg_wr) begin
         buffer_policy_reg <= srs_pkg::srs_policy_type'(acc_wdata[srs_pkg::POLICY_LSB +: 2]);
         buffer_axes_reg <= acc_wdata[srs_pkg::AXES_LSB +: 2];
      end
   end

   // checks
   sequence s_read_req(logic [5:0] a);
      host_req.rd && !host_req.wr && host_req.addr == a;
   endsequence

   sequence s_write_req(logic [5:0] a, logic [7:0] d);
      host_req.wr && host_req.addr == a && host_req.wdata == d;
   endsequence

   a_ro_write_ignored: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      host_req.wr && host_req.addr <= srs_pkg::ADDR_STATUS_LAST |-> !store_we)
      else $error("write to read-only range reached the store");

   a_soft_reset_cmd: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_write_req(srs_pkg::ADDR_SOFT_RESET, srs_pkg::SOFT_RESET_KEY) |=>
      soft_reset_reg && buffer_clear_reg ##1
      buffer_policy_reg == srs_pkg::SRS_POLICY_BYPASS && !soft_reset_reg)
      else $error("reset key did not restore defaults");

   a_trigger_reads_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_read_req(srs_pkg::ADDR_SOFT_RESET) |-> ##2 rd_valid_reg && rd_data_reg == 8'h00)
      else $error("reset command register read nonzero");

   a_latch_bit_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_read_req(srs_pkg::ADDR_INT_LATCH) |-> ##2 rd_valid_reg && !rd_data_reg[7])
      else $error("latch clear bit read back as one");

   a_unmapped_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      host_req.rd && !host_req.wr && !srs_pkg::is_mapped(host_req.addr) |->
      ##2 rd_valid_reg && rd_data_reg == 8'h00)
      else $error("unmapped address read nonzero");

   a_buffer_flush: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      host_req.wr && host_req.addr == srs_pkg::ADDR_BUFFER_CONFIG |=> buffer_clear_reg)
      else $error("buffer configuration write did not flush");

   a_policy_follows: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      host_req.wr && host_req.addr == srs_pkg::ADDR_BUFFER_CONFIG && !soft_reset_reg |=>
      buffer_policy_reg == $past(host_req.wdata[7:6]))
      else $error("buffer policy did not follow the write");

   a_policy_readback: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_read_req(srs_pkg::ADDR_BUFFER_CONFIG) && !soft_reset_reg ##1 !soft_reset_reg |=>
      rd_data_reg[7:6] == $past(buffer_policy_reg))
      else $error("buffer policy readback differs from active policy");

   a_reserved_dropped: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      host_req.wr && host_req.addr == srs_pkg::ADDR_BUFFER_CONFIG && !soft_reset_reg ##2
      s_read_req(srs_pkg::ADDR_BUFFER_CONFIG) && !soft_reset_reg |->
      ##2 rd_data_reg[5:2] == 4'h0)
      else $error("reserved buffer configuration bits were stored");

   a_one_byte_answer: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rd_valid_reg |-> $past(rd_hit, 2))
      else $error("read answer without a request two cycles back");

   a_default_reload: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      soft_reset_reg ##1 s_read_req(srs_pkg::ADDR_SLOPE_THRESHOLD) && !soft_reset_reg |->
      ##2 rd_data_reg == srs_pkg::RST_SLOPE_THRESHOLD)
      else $error("threshold default not restored by soft reset");

   a_policy_only_by_host: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      buffer_policy_reg != $past(buffer_policy_reg) |->
      $past(cfg_wr) || $past(soft_reset_reg))
      else $error("buffer policy changed without a host access");

   a_pop_on_read: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_read_req(srs_pkg::ADDR_BUFFER_READ) |=> buffer_pop_reg ##1 rd_valid_reg)
      else $error("buffer read port read did not pop");

endmodule : srs_register_space

`default_nettype wire

// ===== verification/srs_core_model.sv
// Purpose: sensing core behind the register space: status bytes and buffer head
// Assumes: pop and clear are one-cycle pulses from the register space
// Notes: status byte 0x0E is the fill count, every other byte a fixed pattern
`timescale 1ns/1ps
`default_nettype none

module srs_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic buffer_pop_reg,
   input wire logic buffer_clear_reg,
   output var srs_pkg::srs_status_type core_status,
   output logic [7:0] buffer_data
);
   logic [7:0] fill_reg;
   logic [7:0] head_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_reg <= 8'h03;
         head_reg <= 8'hc0;
      end else if (buffer_clear_reg) begin
         // a clear empties the buffer and restarts the data pattern
         fill_reg <= 8'h00;
         head_reg <= 8'hc0;
      end else if (buffer_pop_reg) begin
         fill_reg <= (fill_reg == 8'h00) ? 8'h00 : fill_reg - 8'h01;
         head_reg <= head_reg + 8'h01;
      end
   end

   always_comb begin
      for (int i = 0; i < 14; i++) begin
         core_status[i] = 8'h50 + 8'(i);
      end
      core_status[14] = fill_reg;
   end

   assign buffer_data = head_reg;
endmodule : srs_core_model

`default_nettype wire

// ===== verification/tb_srs_register_space.sv
// Purpose: self-checking bench for the sensor register space
// Assumes: read answer arrives within a few cycles of the request edge
// Notes: reserved bits are masked out before every compare
`timescale 1ns/1ps
`default_nettype none

module tb_srs_register_space;
   logic sys_clk;
   logic rst_n;
   srs_pkg::srs_req_type host_req;
   srs_pkg::srs_status_type core_status;
   logic [7:0] buffer_data;
   logic [7:0] rd_data_reg;
   logic rd_valid_reg, soft_reset_reg, buffer_clear_reg, buffer_pop_reg, int_latch_clear_reg;
   srs_pkg::srs_policy_type buffer_policy_reg;
   logic [1:0] buffer_axes_reg;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int n_soft = 0, n_clear = 0, n_pop = 0, n_latch = 0;
   int c0;
   logic [7:0] d;
   // address, default, writable mask of every configuration register except the interrupt latch register 0x21
   logic [23:0] tbl [19] = '{24'h22_00ff, 24'h27_00ff, 24'h28_14ff, 24'h29_14ff,
      24'h2a_04c7, 24'h2b_0adf, 24'h2c_187f, 24'h2d_487f, 24'h2e_083f, 24'h30_003f,
      24'h32_0017, 24'h33_f00f, 24'h34_0007, 24'h36_10e7, 24'h37_007f, 24'h38_00ff,
      24'h39_00ff, 24'h3a_00ff, 24'h3e_00c3};

   srs_register_space u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req), .core_status(core_status),
      .buffer_data(buffer_data), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
      .soft_reset_reg(soft_reset_reg), .buffer_clear_reg(buffer_clear_reg),
      .buffer_pop_reg(buffer_pop_reg), .int_latch_clear_reg(int_latch_clear_reg),
      .buffer_policy_reg(buffer_policy_reg), .buffer_axes_reg(buffer_axes_reg)
   );

   srs_core_model u_core (
      .sys_clk(sys_clk), .rst_n(rst_n), .buffer_pop_reg(buffer_pop_reg),
      .buffer_clear_reg(buffer_clear_reg), .core_status(core_status),
      .buffer_data(buffer_data)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // pulses are counted, not timed, so a one-cycle slip still shows as a count
   // counted mid-cycle, clear of the edge at which the tasks return
   always @(negedge sys_clk) begin
      cycles++;
      if (soft_reset_reg === 1'b1) n_soft++;
      if (buffer_clear_reg === 1'b1) n_clear++;
      if (buffer_pop_reg === 1'b1) n_pop++;
      if (int_latch_clear_reg === 1'b1) n_latch++;
      if (cycles == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (failures == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check8

   task automatic check_count(input string name, input int exp, input int got);
      total_checks++;
      if (got != exp) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
      end
   endtask : check_count

   task automatic reg_write(input logic [5:0] a, input logic [7:0] v);
      host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge sys_clk);
      host_req <= '0;
      @(posedge sys_clk);
   endtask : reg_write

   // reserved bits are anded away before use, as the host is told to
   task automatic reg_read(input logic [5:0] a, input logic [7:0] msk, input logic [7:0] exp);
      int n;
      host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      host_req <= '0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (rd_valid_reg !== 1'b1 && n < 4);
      check8("rd_valid", 8'h01, {7'h00, rd_valid_reg});
      check_count("read latency", 1, n);
      check8("rd_data", exp & msk, rd_data_reg & msk);
      @(posedge sys_clk);
   endtask : reg_read

   task automatic check_defaults();
      for (int i = 0; i < 19; i++) begin
         reg_read(tbl[i][21:16], tbl[i][7:0], tbl[i][15:8]);
      end
   endtask : check_defaults

   initial begin
      host_req = '0;
      rst_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check_defaults();
      for (int i = 0; i < 19; i++) begin
         reg_write(tbl[i][21:16], 8'hff);
         reg_read(tbl[i][21:16], tbl[i][7:0], tbl[i][7:0]);
      end
      reg_write(srs_pkg::ADDR_SOFT_RESET, 8'hb5);
      check_count("soft_reset wrong key", 0, n_soft);
      reg_read(srs_pkg::ADDR_SOFT_RESET, 8'hff, 8'h00);
      reg_read(srs_pkg::ADDR_SLOPE_THRESHOLD, 8'hff, 8'hff);
      c0 = n_clear;
      reg_write(srs_pkg::ADDR_SOFT_RESET, srs_pkg::SOFT_RESET_KEY);
      reg_read(srs_pkg::ADDR_SLOPE_THRESHOLD, 8'hff, srs_pkg::RST_SLOPE_THRESHOLD);
      check_count("soft_reset pulse", 1, n_soft);
      check_count("clear on soft reset", c0 + 1, n_clear);
      check8("policy after soft reset", 8'h00, {6'h00, buffer_policy_reg});
      check_defaults();
      reg_write(srs_pkg::ADDR_INT_LATCH, 8'h8a);
      check_count("latch clear pulse", 1, n_latch);
      reg_read(srs_pkg::ADDR_INT_LATCH, 8'h8f, 8'h0a);
      for (int a = 0; a < 15; a++) begin
         reg_write(6'(a), 8'haa);
         d = (a == 14) ? 8'h00 : 8'h50 + 8'(a);
         reg_read(6'(a), 8'hff, d);
      end
      // unmapped places, kept apart from the real map's fully reserved rows
      reg_write(6'h23, 8'h55);
      reg_read(6'h23, 8'hff, 8'h00);
      reg_write(6'h3b, 8'h55);
      reg_read(6'h3b, 8'hff, 8'h00);
      reg_write(6'h2f, 8'h55);
      reg_read(6'h2f, 8'hff, 8'h00);
      for (int p = 0; p < 3; p++) begin
         c0 = n_clear;
         d = {2'(p), 4'h0, 2'(p)};
         reg_write(srs_pkg::ADDR_BUFFER_CONFIG, d);
         check8("policy", 8'(p), {6'h00, buffer_policy_reg});
         check8("axes", 8'(p), {6'h00, buffer_axes_reg});
         check_count("clear on config write", c0 + 1, n_clear);
         reg_read(srs_pkg::ADDR_BUFFER_CONFIG, 8'hc3, d);
      end
      reg_read(6'h0e, 8'hff, 8'h00);
      c0 = n_pop;
      reg_read(srs_pkg::ADDR_BUFFER_READ, 8'hff, 8'hc0);
      reg_read(srs_pkg::ADDR_BUFFER_READ, 8'hff, 8'hc1);
      check_count("pop pulses", c0 + 2, n_pop);
      c0 = n_clear;
      reg_write(srs_pkg::ADDR_WATERMARK, 8'h05);
      check_count("clear on watermark write", c0 + 1, n_clear);
      reg_read(srs_pkg::ADDR_BUFFER_READ, 8'hff, 8'hc0);
      report_and_stop();
   end
endmodule : tb_srs_register_space

`default_nettype wire
